// ---- verilog/uart_fc_map.svh ----
// Register offsets, field positions, reset values and timing counts of the
// serial transceiver with hardware flow control.
// Assumes a 32-bit register port with byte addresses.
`ifndef UART_FC_MAP_SVH
`define UART_FC_MAP_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define ADDR_DATA 32'h4000_8000
`define ADDR_IER 32'h4000_8004
`define ADDR_FCR 32'h4000_8008
`define ADDR_LCR 32'h4000_800c
`define ADDR_MCR 32'h4000_8010
`define ADDR_MSR 32'h4000_8018
`define ADDR_DIV 32'h4000_801c
`define ADDR_IRQ_STAT 32'h4000_8020
`define ADDR_IRQ_MASK 32'h4000_8024

// ****************************************************************
// Field positions
// ****************************************************************
`define IER_MODEM_BIT 3
`define IER_CTS_BIT 7
`define MCR_DTR_BIT 0
`define MCR_RTS_BIT 1
`define MCR_AUTO_RTS_BIT 6
`define MCR_AUTO_CTS_BIT 7
`define FCR_TRIG_HI 7
`define FCR_TRIG_LO 6
`define LCR_WLS_HI 1
`define LCR_WLS_LO 0
`define IRQ_MODEM_BIT 0
`define IRQ_RX_LEVEL_BIT 1
`define IRQ_TX_DONE_BIT 2

// ****************************************************************
// Reset values
// ****************************************************************
`define IER_RESET 8'h00
`define FCR_RESET 8'h00
`define LCR_RESET 8'h00
`define MCR_RESET 8'h00
`define DIV_RESET 16'h0001
`define IRQ_MASK_RESET 3'h0

// ****************************************************************
// Receive trigger levels, in bytes
// ****************************************************************
`define TRIG_LEVEL_0 8'h01
`define TRIG_LEVEL_1 8'h04
`define TRIG_LEVEL_2 8'h08
`define TRIG_LEVEL_3 8'h0e

// ****************************************************************
// Bit timing in oversample ticks, and the last data-bit index of the shortest word
// ****************************************************************
`define TICK_LAST 4'hf
`define TICK_MID 4'h7
`define BITS_MIN 3'h4

`endif

// ---- verilog/uart_fc_pkg.sv ----
// Types shared by the flow-controlled serial transceiver.
// Assumes nothing of its surroundings.
package uart_fc_pkg;

  // ****************************************************************
  // States and carriers
  // ****************************************************************
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic dcd_n;
    logic ri_n;
  } modem_in_type;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } rx_char_type;

endpackage

// ---- verilog/char_receiver.sv ----
// Serial character receiver: start detect, mid-bit sampling, 5 to 8 bits.
// Assumes a 16x oversample tick pulse and a line synchronous to clk.
`timescale 1ns/10ps
`include "uart_fc_map.svh"

module char_receiver import uart_fc_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Timing and format
  input wire logic tick,
  input wire logic [1:0] word_length_select,
  // Line and result
  input wire logic rxd,
  output rx_char_type char_out
);

  rx_state_type state, next_state;
  logic [3:0] tick_cnt, next_tick_cnt;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift;
  rx_char_type next_char;

  // Next-state logic of the receiver
  always_comb begin
    next_state = state;
    next_tick_cnt = tick_cnt;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_char.data = char_out.data;
    next_char.valid = 1'b0;
    unique case (state)
      RX_IDLE: begin
        next_tick_cnt = 4'h0;
        if (!rxd) begin
          next_state = RX_START;
        end
      end
      RX_START: begin
        if (tick) begin
          next_tick_cnt = tick_cnt + 4'h1;
          if (tick_cnt == `TICK_MID) begin
            next_tick_cnt = 4'h0;
            next_bit_cnt = 3'h0;
            next_state = rxd ? RX_IDLE : RX_DATA; // Glitch rejected
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          next_tick_cnt = tick_cnt + 4'h1;
          if (tick_cnt == `TICK_LAST) begin
            next_shift = {rxd, shift[7:1]};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == `BITS_MIN + {1'b0, word_length_select}) begin
              next_state = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          next_tick_cnt = tick_cnt + 4'h1;
          if (tick_cnt == `TICK_LAST) begin
            next_char.valid = 1'b1;
            next_char.data = shift >> (2'h3 - word_length_select); // Right-justify short words
            next_state = RX_IDLE;
          end
        end
      end
    endcase
  end

  // Receiver state registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= RX_IDLE;
      tick_cnt <= 4'h0;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      char_out <= '0;
    end else begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      char_out <= next_char;
    end
  end

endmodule

// ---- verilog/uart_flow_ctrl.sv ----
// Serial transceiver with automatic RTS/CTS flow control, modem status
// interrupt qualification and selectable word length.
// Assumes a simple register port and modem inputs synchronous to clk.
`timescale 1ns/10ps
`include "uart_fc_map.svh"

module uart_flow_ctrl import uart_fc_pkg::*; #(
  parameter int RX_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input bus_req_type bus_req,
  output logic [31:0] rdata,
  // Serial line
  input wire logic rxd,
  output logic txd,
  // Modem lines
  input modem_in_type modem_in,
  output logic rts_n,
  output logic dtr_n,
  // Interrupt
  output logic irq
);

  localparam int PW = $clog2(RX_DEPTH);

  logic [7:0] interrupt_enable_reg, next_ier, fifo_control_reg, next_fcr, character_format_control, next_lcr, modem_control_reg, next_mcr;
  logic [3:0] msr_delta, next_msr_delta;
  modem_in_type modem_prev;
  logic [15:0] div, next_div, div_cnt, next_div_cnt;
  logic [2:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic [31:0] next_rdata;
  logic next_irq, next_rts_n, tick, modem_irq_cond;
  tx_state_type tx_state, next_tx_state;
  logic [7:0] tx_hold, next_tx_hold, tx_shift, next_tx_shift;
  logic tx_hold_full, next_tx_hold_full, next_txd, tx_done;
  logic [3:0] tx_tick, next_tx_tick;
  logic [2:0] tx_bits, next_tx_bits;
  logic [7:0] rx_mem [RX_DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr;
  logic [7:0] count, next_count, trig_level, prev_level;
  rx_char_type rx_char;
  logic push, pop, data_wr;

  // ****************************************************************
  // Register port and interrupts
  // ****************************************************************

  // Decoded strokes that other groups need
  assign data_wr = bus_req.wr && bus_req.addr == `ADDR_DATA && !tx_hold_full;
  assign pop = bus_req.rd && bus_req.addr == `ADDR_DATA && count != 8'h00;

  // Modem interrupt qualification table
  assign modem_irq_cond = interrupt_enable_reg[`IER_MODEM_BIT] && (|msr_delta[3:1]
    || (msr_delta[0] && (!modem_control_reg[`MCR_AUTO_CTS_BIT] || interrupt_enable_reg[`IER_CTS_BIT])));

  // Register writes, status flags and read data
  always_comb begin
    logic [3:0] sets;
    logic [2:0] events;
    sets = '0;
    events = '0;
    next_ier = interrupt_enable_reg;
    next_fcr = fifo_control_reg;
    next_lcr = character_format_control;
    next_mcr = modem_control_reg;
    next_div = div;
    next_irq_mask = irq_mask;
    next_msr_delta = msr_delta;
    next_irq_stat = irq_stat;
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        `ADDR_IER: next_ier = bus_req.wdata[7:0];
        `ADDR_FCR: next_fcr = bus_req.wdata[7:0];
        `ADDR_LCR: next_lcr = bus_req.wdata[7:0];
        `ADDR_MCR: next_mcr = bus_req.wdata[7:0];
        `ADDR_DIV: next_div = bus_req.wdata[15:0];
        `ADDR_MSR: next_msr_delta = msr_delta & ~bus_req.wdata[3:0];
        `ADDR_IRQ_STAT: next_irq_stat = irq_stat & ~bus_req.wdata[2:0];
        `ADDR_IRQ_MASK: next_irq_mask = bus_req.wdata[2:0];
        default: next_ier = interrupt_enable_reg;
      endcase
    end
    // Hardware owns the RTS control bit under auto-RTS
    if (modem_control_reg[`MCR_AUTO_RTS_BIT]) begin
      next_mcr[`MCR_RTS_BIT] = !rts_n;
    end
    // Modem line changes; sets win over clears
    sets[0] = modem_in.cts_n != modem_prev.cts_n;
    sets[1] = modem_in.dsr_n != modem_prev.dsr_n;
    sets[2] = !modem_prev.ri_n && modem_in.ri_n; // Ring indication ended
    sets[3] = modem_in.dcd_n != modem_prev.dcd_n;
    next_msr_delta = next_msr_delta | sets;
    events[`IRQ_MODEM_BIT] = modem_irq_cond;
    events[`IRQ_RX_LEVEL_BIT] = count >= trig_level;
    events[`IRQ_TX_DONE_BIT] = tx_done;
    next_irq_stat = next_irq_stat | events;
    next_irq = |(next_irq_stat & next_irq_mask);
    next_rdata = 32'h0000_0000;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `ADDR_DATA: next_rdata = count != 8'h00 ? {24'h000000, rx_mem[rd_ptr]} : 32'h0000_0000;
        `ADDR_IER: next_rdata = {24'h000000, interrupt_enable_reg};
        `ADDR_FCR: next_rdata = {24'h000000, fifo_control_reg};
        `ADDR_LCR: next_rdata = {24'h000000, character_format_control};
        `ADDR_MCR: next_rdata = {24'h000000, modem_control_reg};
        `ADDR_MSR: next_rdata = {24'h000000, !modem_prev.dcd_n, !modem_prev.ri_n, !modem_prev.dsr_n,
          !modem_prev.cts_n, msr_delta};
        `ADDR_DIV: next_rdata = {16'h0000, div};
        `ADDR_IRQ_STAT: next_rdata = {29'h00000000, irq_stat};
        `ADDR_IRQ_MASK: next_rdata = {29'h00000000, irq_mask};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Register and status storage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_enable_reg <= `IER_RESET;
      fifo_control_reg <= `FCR_RESET;
      character_format_control <= `LCR_RESET;
      modem_control_reg <= `MCR_RESET;
      div <= `DIV_RESET;
      irq_mask <= `IRQ_MASK_RESET;
      msr_delta <= 4'h0;
      irq_stat <= 3'h0;
      modem_prev <= 4'hf;
      rdata <= 32'h0000_0000;
      irq <= 1'b0;
    end else begin
      interrupt_enable_reg <= next_ier;
      fifo_control_reg <= next_fcr;
      character_format_control <= next_lcr;
      modem_control_reg <= next_mcr;
      div <= next_div;
      irq_mask <= next_irq_mask;
      msr_delta <= next_msr_delta;
      irq_stat <= next_irq_stat;
      modem_prev <= modem_in;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  chk_cts_flag: assert property (@(posedge clk) disable iff (!arst_n)
    modem_in.cts_n != modem_prev.cts_n |=> msr_delta[0])
    else $error("CTS change did not set delta CTS");
  chk_cts_masked: assert property (@(posedge clk) disable iff (!arst_n)
    modem_control_reg[`MCR_AUTO_CTS_BIT] && !interrupt_enable_reg[`IER_CTS_BIT] && msr_delta == 4'h1 |-> !modem_irq_cond)
    else $error("Auto-CTS delta raised a modem interrupt without CTS enable");
  chk_modem_lines: assert property (@(posedge clk) disable iff (!arst_n)
    interrupt_enable_reg[`IER_MODEM_BIT] && |msr_delta[3:1] |=> irq_stat[`IRQ_MODEM_BIT])
    else $error("Modem line delta did not raise modem interrupt");
  chk_cts_plain: assert property (@(posedge clk) disable iff (!arst_n)
    interrupt_enable_reg[`IER_MODEM_BIT] && !modem_control_reg[`MCR_AUTO_CTS_BIT] && msr_delta[0] |=> irq_stat[`IRQ_MODEM_BIT])
    else $error("Delta CTS without auto-CTS did not interrupt");

  // ****************************************************************
  // Baud divider and transmitter
  // ****************************************************************

  // Oversample tick every div+1 cycles
  assign tick = div_cnt == 16'h0000;
  assign next_div_cnt = tick ? div : div_cnt - 16'h0001;

  // Transmit holding register and shifter
  always_comb begin
    next_tx_state = tx_state;
    next_tx_hold = tx_hold;
    next_tx_hold_full = tx_hold_full;
    next_tx_shift = tx_shift;
    next_tx_tick = tx_tick;
    next_tx_bits = tx_bits;
    next_txd = txd;
    tx_done = 1'b0;
    if (data_wr) begin
      next_tx_hold = bus_req.wdata[7:0];
      next_tx_hold_full = 1'b1;
    end
    if (tick && tx_state != TX_IDLE) begin
      next_tx_tick = tx_tick + 4'h1;
    end
    unique case (tx_state)
      TX_IDLE: begin
        next_txd = 1'b1;
        next_tx_tick = 4'h0;
        // CTS is sampled only here, after the stop bit
        if (tx_hold_full && (!modem_control_reg[`MCR_AUTO_CTS_BIT] || !modem_in.cts_n)) begin
          next_tx_shift = tx_hold;
          next_tx_hold_full = 1'b0;
          next_txd = 1'b0; // Start bit
          next_tx_state = TX_START;
        end
      end
      TX_START: begin
        if (tick && tx_tick == `TICK_LAST) begin
          next_txd = tx_shift[0];
          next_tx_shift = tx_shift >> 1;
          next_tx_bits = 3'h0;
          next_tx_state = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tick && tx_tick == `TICK_LAST) begin
          next_tx_bits = tx_bits + 3'h1;
          next_txd = tx_shift[0];
          next_tx_shift = tx_shift >> 1;
          if (tx_bits == `BITS_MIN + {1'b0, character_format_control[`LCR_WLS_HI:`LCR_WLS_LO]}) begin
            next_txd = 1'b1;
            next_tx_state = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (tick && tx_tick == `TICK_LAST) begin
          tx_done = 1'b1;
          next_tx_state = TX_IDLE;
        end
      end
    endcase
  end

  // Transmitter and divider storage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= 16'h0000;
      tx_state <= TX_IDLE;
      tx_hold <= 8'h00;
      tx_hold_full <= 1'b0;
      tx_shift <= 8'h00;
      tx_tick <= 4'h0;
      tx_bits <= 3'h0;
      txd <= 1'b1;
    end else begin
      div_cnt <= next_div_cnt;
      tx_state <= next_tx_state;
      tx_hold <= next_tx_hold;
      tx_hold_full <= next_tx_hold_full;
      tx_shift <= next_tx_shift;
      tx_tick <= next_tx_tick;
      tx_bits <= next_tx_bits;
      txd <= next_txd;
    end
  end

  chk_cts_hold: assert property (@(posedge clk) disable iff (!arst_n)
    tx_state == TX_IDLE && modem_control_reg[`MCR_AUTO_CTS_BIT] && modem_in.cts_n |=> tx_state == TX_IDLE && txd)
    else $error("Character started while CTS was high");
  chk_cts_ignored: assert property (@(posedge clk) disable iff (!arst_n)
    tx_state == TX_IDLE && !modem_control_reg[`MCR_AUTO_CTS_BIT] && tx_hold_full |=> tx_state == TX_START && !txd)
    else $error("Transmitter waited without auto-CTS");
  chk_word_bits: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(tx_state == TX_STOP) |-> $past(tx_bits) == `BITS_MIN + {1'b0, character_format_control[`LCR_WLS_HI:`LCR_WLS_LO]})
    else $error("Wrong number of data bits sent");

  // ****************************************************************
  // Receiver, receive FIFO and RTS
  // ****************************************************************

  char_receiver u_receiver (
    .clk(clk),
    .arst_n(arst_n),
    .tick(tick),
    .word_length_select(character_format_control[`LCR_WLS_HI:`LCR_WLS_LO]),
    .rxd(rxd),
    .char_out(rx_char)
  );

  // Depth above the top trigger leaves room for a late byte
  assign push = rx_char.valid && count != 8'(RX_DEPTH);

  // Trigger level and the level below it
  always_comb begin
    unique case (fifo_control_reg[`FCR_TRIG_HI:`FCR_TRIG_LO])
      2'h0: begin trig_level = `TRIG_LEVEL_0; prev_level = 8'h00; end
      2'h1: begin trig_level = `TRIG_LEVEL_1; prev_level = `TRIG_LEVEL_0; end
      2'h2: begin trig_level = `TRIG_LEVEL_2; prev_level = `TRIG_LEVEL_1; end
      2'h3: begin trig_level = `TRIG_LEVEL_3; prev_level = `TRIG_LEVEL_2; end
    endcase
  end

  // Fill count and RTS level
  always_comb begin
    next_count = count + {7'h00, push} - {7'h00, pop};
    next_rts_n = rts_n;
    if (modem_control_reg[`MCR_AUTO_RTS_BIT]) begin
      if (count >= trig_level) begin
        next_rts_n = 1'b1;
      end else if (count <= prev_level) begin
        next_rts_n = 1'b0;
      end
    end else begin
      next_rts_n = !modem_control_reg[`MCR_RTS_BIT];
    end
  end

  // FIFO storage, pointers and modem outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= 8'h00;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
    end else begin
      if (push) begin
        rx_mem[wr_ptr] <= rx_char.data;
        wr_ptr <= PW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= PW'(rd_ptr + 1'b1);
      end
      count <= next_count;
      rts_n <= next_rts_n;
      dtr_n <= !modem_control_reg[`MCR_DTR_BIT];
    end
  end

  chk_rts_stop: assert property (@(posedge clk) disable iff (!arst_n)
    modem_control_reg[`MCR_AUTO_RTS_BIT] && count >= trig_level |=> rts_n)
    else $error("RTS not deasserted at trigger level");
  chk_rts_resume: assert property (@(posedge clk) disable iff (!arst_n)
    modem_control_reg[`MCR_AUTO_RTS_BIT] && count <= prev_level |=> !rts_n)
    else $error("RTS not reasserted at lower level");
  chk_rts_manual: assert property (@(posedge clk) disable iff (!arst_n)
    !modem_control_reg[`MCR_AUTO_RTS_BIT] |=> rts_n == !$past(modem_control_reg[`MCR_RTS_BIT]))
    else $error("RTS did not follow control bit");
  chk_rts_mirror: assert property (@(posedge clk) disable iff (!arst_n)
    $past(modem_control_reg[`MCR_AUTO_RTS_BIT]) |-> modem_control_reg[`MCR_RTS_BIT] == !$past(rts_n))
    else $error("RTS control bit does not mirror the output");

endmodule

// ---- verification/remote_port.sv ----
// Model of the remote serial port facing the transceiver.
// Assumes one bit lasts BIT_CYC clk cycles and lines change at rising edges.
`timescale 1ns/10ps

module remote_port #(
  parameter int BIT_CYC = 16
) (
  // Clock
  input wire logic clk,
  // Commands from the bench
  input wire logic hold,
  input wire logic [3:0] nbits,
  // Serial and modem lines
  input wire logic txd,
  output logic rxd,
  output logic cts_n,
  // Characters taken off the line
  output logic [7:0] got,
  output int got_count
);
  logic [7:0] sh;

  // ********
  // Line drivers and sampler
  // ********
  initial begin
    rxd = 1'b1;
    cts_n = 1'b1;
    got = 8'h00;
    got_count = 0;
  end

  // Stop request goes out one clk cycle later, long before any mid stop bit
  always @(posedge clk) begin
    cts_n <= hold;
  end

  // Start bit, nbits data bits LSB first, one stop bit
  task automatic send_char(input logic [7:0] d);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      rxd <= d[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BIT_CYC) @(posedge clk);
  endtask

  // Samples each transmitted data bit in its middle
  always begin
    @(negedge txd);
    sh = 8'h00;
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      sh[i] = txd;
    end
    got <= sh;
    got_count <= got_count + 1;
  end
endmodule

// ---- verification/tb_uart_flow_ctrl.sv ----
// Self-checking bench of the flow-controlled serial transceiver.
// Assumes the remote port model and divisor 0, so a bit is 16 clk cycles.
`timescale 1ns/10ps
`include "uart_fc_map.svh"

module tb_uart_flow_ctrl import uart_fc_pkg::*; ();
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  bus_req_type bus_req = '0;
  logic [31:0] rdata;
  logic rxd, txd, rts_n, dtr_n, irq, peer_cts_n;
  logic [3:0] lv = 4'hf;
  logic [3:0] nbits = 4'h5;
  logic [7:0] got;
  int got_count;
  int failures = 0;
  int check_count = 0;
  modem_in_type modem_in;
  logic [31:0] rst_addr [8] = '{`ADDR_IER, `ADDR_FCR, `ADDR_LCR, `ADDR_MCR, `ADDR_MSR, `ADDR_DIV,
    `ADDR_IRQ_MASK, 32'h4000_8014};
  logic [31:0] rst_val [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
  // Fields: cts enable, modem enable, auto-cts, mask, line, delta, irq
  logic [7:0] irq_case [9] = '{8'h12, 8'h53, 8'h72, 8'hf3, 8'h77, 8'h7f, 8'h78, 8'h7b, 8'h46};

  // ********
  // Design, far end and clock
  // ********
  assign modem_in = {peer_cts_n, lv[1], lv[3], lv[2]};
  uart_flow_ctrl #(.RX_DEPTH(16)) u_dut (.clk(clk), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
    .rxd(rxd), .txd(txd), .modem_in(modem_in), .rts_n(rts_n), .dtr_n(dtr_n), .irq(irq));
  remote_port #(.BIT_CYC(16)) u_peer (.clk(clk), .hold(lv[0]), .nbits(nbits), .txd(txd), .rxd(rxd),
    .cts_n(peer_cts_n), .got(got), .got_count(got_count));
  always #2 clk = ~clk;

  // ********
  // Tasks
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s, seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string msg);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1;
    check(rdata, e, msg);
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wait_rx(input int n0);
    for (int i = 0; i < 600 && got_count == n0; i++) @(posedge clk);
    #1;
    check(got_count, n0 + 1, "character count");
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ********
  // Tests
  // ********
  initial begin
    int n;
    int bad;
    int k;
    logic [7:0] m;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    settle();
    check({rts_n, txd, irq}, 3'b110, "idle outputs");
    for (int i = 0; i < 8; i++) rd_chk(rst_addr[i], rst_val[i], "reset value");
    // Every word length both ways, CTS high and ignored
    bus_wr(`ADDR_DIV, 32'h0);
    for (int w = 0; w < 4; w++) begin
      n = got_count;
      m = 8'hff >> (3 - w);
      bus_wr(`ADDR_LCR, 32'(w));
      nbits <= 4'(5 + w);
      bus_wr(`ADDR_DATA, 32'ha5);
      wait_rx(n);
      check(got, 8'ha5 & m, "sent character");
      u_peer.send_char(8'h3c);
      rd_chk(`ADDR_DATA, 8'h3c & m, "received character");
    end
    // Automatic RTS at trigger setting 2
    bus_wr(`ADDR_LCR, 32'h3);
    nbits <= 4'h8;
    bus_wr(`ADDR_FCR, 32'h80);
    bus_wr(`ADDR_MCR, 32'h40);
    for (int i = 1; i <= 8; i++) begin
      settle();
      check(rts_n, 1'b0, "rts below trigger");
      u_peer.send_char(8'(i));
    end
    settle();
    check(rts_n, 1'b1, "rts at trigger");
    rd_chk(`ADDR_MCR, 32'h40, "rts bit mirrors line");
    bus_wr(`ADDR_MCR, 32'h42);
    rd_chk(`ADDR_MCR, 32'h40, "rts bit write ignored");
    u_peer.send_char(8'h09);
    for (int i = 1; i <= 9; i++) begin
      rd_chk(`ADDR_DATA, 32'(i), "fifo order");
      settle();
      check(rts_n, 32'(i < 5), "rts release");
    end
    rd_chk(`ADDR_MCR, 32'h42, "rts bit mirrors low line");
    // The write that turns auto-RTS off still has the RTS bit mirrored, so write again
    bus_wr(`ADDR_MCR, 32'h0);
    bus_wr(`ADDR_MCR, 32'h0);
    settle();
    check(rts_n, 1'b1, "manual rts off");
    bus_wr(`ADDR_MCR, 32'h2);
    settle();
    check(rts_n, 1'b0, "manual rts on");
    check(dtr_n, 1'b1, "dtr off");
    bus_wr(`ADDR_MCR, 32'h3);
    settle();
    check({rts_n, dtr_n}, 2'b00, "dtr on");
    // Automatic CTS: CTS raised during one character holds the next
    @(posedge clk);
    lv[0] <= 1'b0;
    bus_wr(`ADDR_MCR, 32'h80);
    n = got_count;
    bus_wr(`ADDR_DATA, 32'h91);
    for (int i = 0; i < 50 && txd !== 1'b0; i++) @(posedge clk);
    lv[0] <= 1'b1;
    bus_wr(`ADDR_DATA, 32'h22);
    wait_rx(n);
    check(got, 8'h91, "first character");
    bad = 0;
    repeat (80) begin
      @(posedge clk);
      if (txd !== 1'b1) bad++;
    end
    check(bad, 0, "line idle while cts high");
    @(posedge clk);
    lv[0] <= 1'b0;
    wait_rx(n + 1);
    check(got, 8'h22, "held character");
    // Modem status interrupt qualification
    for (int c = 0; c < 9; c++) begin
      k = irq_case[c][3:2];
      bus_wr(`ADDR_MSR, 32'hf);
      bus_wr(`ADDR_IRQ_STAT, 32'h7);
      bus_wr(`ADDR_IER, {24'h0, irq_case[c][7], 3'h0, irq_case[c][6], 3'h0});
      bus_wr(`ADDR_MCR, {24'h0, irq_case[c][5], 7'h0});
      bus_wr(`ADDR_IRQ_MASK, {31'h0, irq_case[c][4]});
      settle();
      check(irq, 1'b0, "irq after clear");
      @(posedge clk);
      lv[k] <= ~lv[k];
      repeat (6) @(posedge clk);
      #1;
      check(irq, irq_case[c][0], "modem interrupt");
      rd_chk(`ADDR_MSR, {24'h0, ~lv[3], ~lv[2], ~lv[1], ~lv[0], 4'(irq_case[c][1] << k)}, "deltas");
    end
    stop_test();
  end

  // Whole run needs about 3200 cycles
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule
